// ---- rtl/pcsia_core.sv ----
module pcsia_core (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Program flow from the execution logic.
  input wire pcsia_pkg::pcsia_flow_s flow,
  input wire logic low_byte_wr,
  input wire logic [7:0] low_byte_wdata,
  input wire logic latch_wr,
  input wire logic [4:0] latch_wdata,
  // Data file access from the execution logic.
  input wire pcsia_pkg::pcsia_file_req_s file_req,
  input wire logic fsp_wr,
  input wire logic [7:0] fsp_wdata,
  input wire logic indirect_bank_bit,
  input wire logic [7:0] mem_rdata,
  // Program flow outputs.
  output logic [12:0] pc,
  output logic [7:0] pc_low_byte_register,
  output logic [4:0] pc_high_latch,
  // Data file outputs.
  output logic [7:0] file_select_pointer,
  output pcsia_pkg::pcsia_mem_req_s mem_req,
  output logic [7:0] file_rdata
);
  logic [12:0] pc_q, pc_d;
  logic [4:0] latch_q;
  logic [2:0] sp_q;
  logic [12:0] stack_q [pcsia_pkg::STACK_DEPTH];
  logic [7:0] fsp_q;
  logic push, pop;
  logic [2:0] pop_idx;
  logic ind_hit, ind_self;
  logic [7:0] sel_addr;

  // Pushes store the return point, which is the next sequential address.
  // A low byte write overrides the op, so it must not move the stack either.
  assign push = !low_byte_wr &&
                ((flow.op == pcsia_pkg::PCSIA_OP_JUMP) ||
                 (flow.op == pcsia_pkg::PCSIA_OP_INTERRUPT));
  assign pop = !low_byte_wr &&
               (flow.op == pcsia_pkg::PCSIA_OP_RETURN);
  // The pointer wraps silently in both directions, with no flag.
  assign pop_idx = sp_q - 3'h1;

  always_comb begin
    pc_d = pc_q + pcsia_pkg::PC_STEP;
    if (low_byte_wr) begin
      pc_d = {latch_q, low_byte_wdata};
    end else begin
      unique case (flow.op)
        pcsia_pkg::PCSIA_OP_NEXT: pc_d = pc_q + pcsia_pkg::PC_STEP;
        pcsia_pkg::PCSIA_OP_JUMP,
        pcsia_pkg::PCSIA_OP_BRANCH: pc_d = {latch_q[4:3], flow.target};
        pcsia_pkg::PCSIA_OP_RETURN: pc_d = stack_q[pop_idx];
        pcsia_pkg::PCSIA_OP_INTERRUPT: pc_d = pcsia_pkg::INT_VECTOR;
        pcsia_pkg::PCSIA_OP_HOLD: pc_d = pc_q;
        default: pc_d = pc_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= pcsia_pkg::PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // The latch changes only on its own write, never on push or pop.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= pcsia_pkg::LATCH_RESET;
    end else if (latch_wr) begin
      latch_q <= latch_wdata;
    end
  end

  // The pointer has no port, so software can neither see nor move it.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_q <= pcsia_pkg::SP_RESET;
    end else if (push) begin
      sp_q <= sp_q + 3'h1;
    end else if (pop) begin
      sp_q <= pop_idx;
    end
  end

  // Stack storage is private, apart from both address spaces.
  always_ff @(posedge core_clk) begin
    if (push) begin
      stack_q[sp_q] <= pc_q + pcsia_pkg::PC_STEP;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fsp_q <= pcsia_pkg::FSP_RESET;
    end else if (fsp_wr) begin
      fsp_q <= fsp_wdata;
    end
  end

  assign ind_hit = (file_req.addr == pcsia_pkg::INDIRECT_PORT_ADDR);
  assign ind_self = ind_hit &&
                    (fsp_q == pcsia_pkg::INDIRECT_PORT_ADDR);
  assign sel_addr = ind_hit ? fsp_q : file_req.addr;

  // Handshake-style request outputs are combinational for same-cycle access.
  always_comb begin
    mem_req.addr = {indirect_bank_bit, sel_addr};
    mem_req.wdata = file_req.wdata;
    mem_req.read = file_req.read && !ind_self;
    mem_req.write = file_req.write && !ind_self;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      file_rdata <= 8'h00;
    end else if (file_req.read) begin
      file_rdata <= ind_self ? pcsia_pkg::INDIRECT_SELF_READ : mem_rdata;
    end
  end

  assign pc = pc_q;
  assign pc_low_byte_register = pc_q[7:0];
  assign pc_high_latch = latch_q;
  assign file_select_pointer = fsp_q;

  AST_RESET_PC: assert property (@(posedge core_clk)
    $rose(reset_n) |-> $past(pc_q) == 13'h0000)
    else $error("pc not cleared by reset");

  AST_LOW_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n)
    low_byte_wr |=> pc_q == {$past(latch_q), $past(low_byte_wdata)})
    else $error("low byte write did not load all 13 bits");

  AST_UPPER_FROM_LATCH: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    low_byte_wr |=> pc_q[12:8] == $past(latch_q))
    else $error("upper bits not taken from latch");

  AST_JUMP_TOP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!low_byte_wr && (flow.op == pcsia_pkg::PCSIA_OP_JUMP ||
     flow.op == pcsia_pkg::PCSIA_OP_BRANCH))
    |=> pc_q == {$past(latch_q[4:3]), $past(flow.target)})
    else $error("jump target wrong");

  sequence s_call;
    !low_byte_wr && flow.op == pcsia_pkg::PCSIA_OP_JUMP;
  endsequence
  sequence s_ret;
    !low_byte_wr && !latch_wr && flow.op == pcsia_pkg::PCSIA_OP_RETURN;
  endsequence

  AST_CALL_RETURN: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    s_call ##1 s_ret |=>
    pc_q == $past(pc_q, 2) + pcsia_pkg::PC_STEP)
    else $error("call return pairing broken");

  AST_LATCH_KEPT: assert property (@(posedge core_clk) disable iff (!reset_n)
    ((push || pop) && !latch_wr) |=> $stable(latch_q))
    else $error("latch changed by stack action");

  AST_SP_WRAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    push |=> sp_q == $past(sp_q) + 3'h1)
    else $error("stack pointer did not advance");

  AST_POP_WRAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (pop && !push) |=> sp_q == $past(sp_q) - 3'h1)
    else $error("stack pointer did not retreat");

  AST_SELF_READ: assert property (@(posedge core_clk) disable iff (!reset_n)
    (file_req.read && ind_self) |=> file_rdata == 8'h00)
    else $error("self read not zero");

  AST_SELF_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n)
    ind_self |-> !mem_req.write && !mem_req.read)
    else $error("self access reached storage");

  AST_EADDR: assert property (@(posedge core_clk) disable iff (!reset_n)
    ind_hit |-> mem_req.addr == {indirect_bank_bit, fsp_q})
    else $error("effective address wrong");

  AST_NEXT_STEP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!low_byte_wr && flow.op == pcsia_pkg::PCSIA_OP_NEXT)
    |=> pc_q == $past(pc_q) + pcsia_pkg::PC_STEP)
    else $error("sequential step wrong");

  AST_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!low_byte_wr && flow.op == pcsia_pkg::PCSIA_OP_HOLD)
    |=> $stable(pc_q))
    else $error("pc moved while held");

  AST_INT_VECTOR: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!low_byte_wr && flow.op == pcsia_pkg::PCSIA_OP_INTERRUPT)
    |=> pc_q == pcsia_pkg::INT_VECTOR)
    else $error("interrupt did not reach vector");

  AST_PUSH_VALUE: assert property (@(posedge core_clk) disable iff (!reset_n)
    push |=> stack_q[$past(sp_q)] == $past(pc_q) + pcsia_pkg::PC_STEP)
    else $error("pushed return point wrong");

  AST_RET_POP: assert property (@(posedge core_clk) disable iff (!reset_n)
    pop |=> pc_q == $past(stack_q[pop_idx]))
    else $error("return did not load top entry");

  AST_LOW_NO_STACK: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    low_byte_wr |=> $stable(sp_q))
    else $error("low byte write moved the stack");

  AST_FSP_LOAD: assert property (@(posedge core_clk) disable iff (!reset_n)
    fsp_wr |=> fsp_q == $past(fsp_wdata))
    else $error("file pointer not loaded");

  AST_DIRECT_ADDR: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    !ind_hit |-> mem_req.addr[7:0] == file_req.addr)
    else $error("direct address altered");

  AST_READ_DATA: assert property (@(posedge core_clk) disable iff (!reset_n)
    (file_req.read && !ind_self) |=> file_rdata == $past(mem_rdata))
    else $error("read data not captured");
endmodule : pcsia_core

// ---- rtl/pcsia_pkg.sv ----
package pcsia_pkg;
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int FADDR_W = 8;
  localparam int EADDR_W = 9;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [4:0] LATCH_RESET = 5'h00;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [FADDR_W-1:0] FSP_RESET = 8'h00;
  localparam logic [FADDR_W-1:0] INDIRECT_PORT_ADDR = 8'h00;
  localparam logic [7:0] INDIRECT_SELF_READ = 8'h00;
  localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

  typedef enum logic [2:0] {
    PCSIA_OP_NEXT,
    PCSIA_OP_JUMP,
    PCSIA_OP_BRANCH,
    PCSIA_OP_RETURN,
    PCSIA_OP_INTERRUPT,
    PCSIA_OP_HOLD
  } pcsia_op_e;

  typedef struct packed {
    pcsia_op_e op;
    logic [10:0] target;
  } pcsia_flow_s;

  typedef struct packed {
    logic read;
    logic write;
    logic [FADDR_W-1:0] addr;
    logic [7:0] wdata;
  } pcsia_file_req_s;

  typedef struct packed {
    logic read;
    logic write;
    logic [EADDR_W-1:0] addr;
    logic [7:0] wdata;
  } pcsia_mem_req_s;
endpackage : pcsia_pkg

// ---- verification/pcsia_data_mem.sv ----
module pcsia_data_mem (
  // Clock.
  input wire logic core_clk,
  // Request from the core and data back.
  input wire pcsia_pkg::pcsia_mem_req_s mem_req,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [512];
  logic [7:0] idle_q = 8'h00;
  // Idle data moves every cycle so that a stale read cannot pass.
  always_ff @(posedge core_clk) begin
    idle_q <= idle_q + 8'h3B;
    if (mem_req.write) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end
  assign mem_rdata = mem_req.read ? mem[mem_req.addr] : idle_q;
endmodule : pcsia_data_mem

// ---- verification/test_pc_stack_indirect_addressing.sv ----
module test_pc_stack_indirect_addressing;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    pcsia_pkg::pcsia_op_e op;
    logic [10:0] tgt;
    logic lwr;
    logic [7:0] ldata;
    logic [12:0] exp_pc;
  } pcsia_row_s;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  pcsia_pkg::pcsia_flow_s flow;
  pcsia_pkg::pcsia_file_req_s file_req;
  pcsia_pkg::pcsia_mem_req_s mem_req;
  logic low_byte_wr, latch_wr, fsp_wr, indirect_bank_bit;
  logic [7:0] low_byte_wdata, fsp_wdata, mem_rdata, file_rdata;
  logic [7:0] pc_low_byte_register, file_select_pointer;
  logic [4:0] latch_wdata, pc_high_latch;
  logic [12:0] pc;
  int miscompares = 0;
  int samples_checked = 0;
  pcsia_row_s rows [8];
  always #25 core_clk = ~core_clk;
  pcsia_core i_pcsia_core (.core_clk, .reset_n, .flow, .low_byte_wr,
    .low_byte_wdata, .latch_wr, .latch_wdata, .file_req, .fsp_wr, .fsp_wdata,
    .indirect_bank_bit, .mem_rdata, .pc, .pc_low_byte_register,
    .pc_high_latch, .file_select_pointer, .mem_req, .file_rdata);
  pcsia_data_mem i_pcsia_data_mem (.core_clk, .mem_req, .mem_rdata);
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input pcsia_row_s r);
    flow = '{op: r.op, target: r.tgt};
    low_byte_wr = r.lwr;
    low_byte_wdata = r.ldata;
    @(negedge core_clk);
  endtask : step
  task automatic complete_run;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    flow = '{op: pcsia_pkg::PCSIA_OP_HOLD, target: 11'h000};
    {low_byte_wr, latch_wr, fsp_wr, indirect_bank_bit} = 4'h0;
    low_byte_wdata = 8'h00;
    latch_wdata = 5'h1A;
    fsp_wdata = 8'h40;
    file_req = '0;
    rows[0] = '{pcsia_pkg::PCSIA_OP_NEXT, 11'h000, 1'b0, 8'h00, 13'h0001};
    rows[1] = '{pcsia_pkg::PCSIA_OP_JUMP, 11'h123, 1'b0, 8'h00, 13'h1923};
    rows[2] = '{pcsia_pkg::PCSIA_OP_NEXT, 11'h000, 1'b1, 8'h45, 13'h1A45};
    rows[3] = '{pcsia_pkg::PCSIA_OP_BRANCH, 11'h7FF, 1'b0, 8'h00, 13'h1FFF};
    rows[4] = '{pcsia_pkg::PCSIA_OP_INTERRUPT, 11'h000, 1'b0, 8'h00, 13'h0004};
    rows[5] = '{pcsia_pkg::PCSIA_OP_RETURN, 11'h000, 1'b0, 8'h00, 13'h0000};
    rows[6] = '{pcsia_pkg::PCSIA_OP_RETURN, 11'h000, 1'b0, 8'h00, 13'h0002};
    rows[7] = '{pcsia_pkg::PCSIA_OP_HOLD, 11'h000, 1'b0, 8'h00, 13'h0002};
    repeat (3) @(negedge core_clk);
    chk(pc, 13'h0000);
    reset_n = 1'b1;
    latch_wr = 1'b1;
    @(negedge core_clk);
    latch_wr = 1'b0;
    foreach (rows[i]) begin
      step(rows[i]);
      chk(pc, rows[i].exp_pc);
      chk({5'h00, pc_low_byte_register}, {5'h00, rows[i].exp_pc[7:0]});
    end
    // Nine calls overrun the eight slots, so the oldest return is lost.
    for (int i = 1; i <= 9; i++) begin
      step('{pcsia_pkg::PCSIA_OP_JUMP, 11'(i), 1'b0, 8'h00, 13'h0});
      chk(pc, 13'h1800 + 13'(i));
    end
    for (int k = 0; k < 9; k++) begin
      step('{pcsia_pkg::PCSIA_OP_RETURN, 11'h000, 1'b0, 8'h00, 13'h0});
      chk(pc, 13'h1809 - 13'(k % 8));
    end
    chk({8'h00, pc_high_latch}, 13'h001A);
    flow.op = pcsia_pkg::PCSIA_OP_HOLD;
    fsp_wr = 1'b1;
    indirect_bank_bit = 1'b1;
    @(negedge core_clk);
    fsp_wr = 1'b0;
    chk({5'h00, file_select_pointer}, 13'h0040);
    file_req = '{1'b0, 1'b1, 8'h00, 8'h5A};
    #1 chk({4'h0, mem_req.addr}, 13'h0140);
    @(negedge core_clk);
    file_req = '{1'b1, 1'b0, 8'h00, 8'h00};
    @(negedge core_clk);
    chk({5'h00, file_rdata}, 13'h005A);
    file_req = '0;
    fsp_wr = 1'b1;
    fsp_wdata = 8'h00;
    @(negedge core_clk);
    fsp_wr = 1'b0;
    file_req = '{1'b0, 1'b1, 8'h00, 8'hC3};
    #1 chk({12'h000, mem_req.write}, 13'h0000);
    @(negedge core_clk);
    file_req = '{1'b1, 1'b0, 8'h00, 8'h00};
    @(negedge core_clk);
    chk({5'h00, file_rdata}, 13'h0000);
    file_req = '0;
    // A computed jump past a low byte wrap bumps the latch first.
    latch_wdata = 5'h1B;
    latch_wr = 1'b1;
    @(negedge core_clk);
    latch_wr = 1'b0;
    step('{pcsia_pkg::PCSIA_OP_HOLD, 11'h000, 1'b1, 8'h02, 13'h0});
    low_byte_wr = 1'b0;
    chk(pc, 13'h1B02);
    reset_n = 1'b0;
    #1 chk(pc, 13'h0000);
    @(negedge core_clk);
    reset_n = 1'b1;
    complete_run();
  end
endmodule : test_pc_stack_indirect_addressing
